// File: dbmc_defs.svh
`ifndef DBMC_DEFS_SVH
`define DBMC_DEFS_SVH

// Register offsets on the control port
`define DBMC_ADDR_W           8
`define DBMC_OFS_PIN_FWD      8'h31
`define DBMC_OFS_BOOT_SRC     8'h32
`define DBMC_OFS_SOFT_IRQ     8'h33
`define DBMC_OFS_MEM_SEC      8'h34
`define DBMC_OFS_DEC_RST      8'h35

// Field positions
`define DBMC_BIT_FWD_PIN2     6
`define DBMC_BIT_FWD_PIN0     4
`define DBMC_BIT_BOOT_RAM     1
`define DBMC_BIT_DEF_COEF     0
`define DBMC_BIT_SOFT_IRQ     0
`define DBMC_BIT_RD_EN        3
`define DBMC_BIT_DEC_DIS      2
`define DBMC_BIT_DEC_RST      0

// Reset values
`define DBMC_RST_PIN_FWD      8'h00
`define DBMC_RST_BOOT_SRC     8'h00
`define DBMC_RST_MEM_SEC      8'h00

// Seed table
`define DBMC_SEED_0           8'ha5
`define DBMC_SEED_1           8'hb6
`define DBMC_SEED_2           8'h94
`define DBMC_SEED_3           8'he2

`endif

// File: dbmc_pkg.sv
package dbmc_pkg;
  typedef logic [7:0] dbmc_byte_t;
  typedef logic [1:0] dbmc_seed_sel_t;
  // Soft interrupt handshake states
  typedef enum logic [0:0] {DBMC_IRQ_IDLE, DBMC_IRQ_PEND} dbmc_irq_e;
endpackage

// File: dbmc_seed_rom.sv
`include "dbmc_defs.svh"

// Maps the two-bit seed selection onto the CRC seed byte
module dbmc_seed_rom (
  input  wire logic [1:0] i_sel,   // Seed select
  output logic      [7:0] o_seed   // Seed value
);
  timeunit 1ns;
  timeprecision 100ps;
  // Small constant table, purely combinational
  always_comb begin
    case (i_sel)
      2'h0:    o_seed = `DBMC_SEED_0;
      2'h1:    o_seed = `DBMC_SEED_1;
      2'h2:    o_seed = `DBMC_SEED_2;
      default: o_seed = `DBMC_SEED_3;
    endcase
  end
endmodule

// File: dbmc_ctrl.sv
`include "dbmc_defs.svh"

module dbmc_ctrl
  import dbmc_pkg::*;
(
  input  wire logic            i_mclk,          // Control clock
  input  wire logic            i_rst_n,         // Sync reset, active low
  input  wire logic            i_wr,            // Register write strobe
  input  wire logic            i_rd,            // Register read strobe
  input  wire logic [7:0]      i_addr,          // Register offset
  input  wire dbmc_pkg::dbmc_byte_t i_wdata,    // Write data
  output dbmc_pkg::dbmc_byte_t o_rdata,         // Read data, one cycle after i_rd
  input  wire logic            i_gp_pin_0,      // General-purpose pin 0
  input  wire logic            i_gp_pin_2,      // General-purpose pin 2
  output logic                 o_proc_gp0,      // Gated pin 0 to processor
  output logic                 o_proc_gp2,      // Gated pin 2 to processor
  output logic                 o_boot_from_ram, // Boot from program RAM
  output logic                 o_use_default_coefs, // Use coefficient ROM
  output logic                 o_proc_soft_irq, // Interrupt to processor
  input  wire logic            i_proc_irq_ack,  // Processor acknowledge
  input  wire logic            i_mem_rd,        // Processor memory read valid
  input  wire dbmc_pkg::dbmc_byte_t i_mem_rdata, // Raw memory read data
  output dbmc_pkg::dbmc_byte_t o_mem_rdata,     // Gated memory read data
  output logic                 o_decrypt_enable, // Decryption active
  output dbmc_pkg::dbmc_byte_t o_crc_seed,      // Selected CRC seed
  output logic                 o_decrypt_block_reset // One-cycle reset pulse
);

  // Same time scope as the bench, so mixed-scope elaboration stays clean
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0]     pin_fwd_r;
  logic [7:0]     boot_src_r;
  logic [7:0]     mem_sec_r;
  dbmc_irq_e      irq_state_r;
  logic [7:0]     seed_w;
  logic           wr_fwd, wr_boot, wr_irq, wr_sec, wr_drst;

  // Address decode for writes
  always_comb begin
    wr_fwd  = 1'b0;
    wr_boot = 1'b0;
    wr_irq  = 1'b0;
    wr_sec  = 1'b0;
    wr_drst = 1'b0;
    if (i_wr && i_addr == `DBMC_OFS_PIN_FWD) begin
      wr_fwd = 1'b1;
    end else if (i_wr && i_addr == `DBMC_OFS_BOOT_SRC) begin
      wr_boot = 1'b1;
    end else if (i_wr && i_addr == `DBMC_OFS_SOFT_IRQ) begin
      wr_irq = 1'b1;
    end else if (i_wr && i_addr == `DBMC_OFS_MEM_SEC) begin
      wr_sec = 1'b1;
    end else if (i_wr && i_addr == `DBMC_OFS_DEC_RST) begin
      wr_drst = 1'b1;
    end
  end

  // Pin forwarding register, all bits kept so reserved bits read back
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pin_fwd_r <= `DBMC_RST_PIN_FWD;
    end else if (wr_fwd) begin
      pin_fwd_r <= i_wdata;
    end
  end

  // Boot and coefficient source register
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      boot_src_r <= `DBMC_RST_BOOT_SRC;
    end else if (wr_boot) begin
      boot_src_r <= i_wdata;
    end
  end

  // Memory security register
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mem_sec_r <= `DBMC_RST_MEM_SEC;
    end else if (wr_sec) begin
      mem_sec_r <= i_wdata;
    end
  end

  // Soft interrupt: a host set in the same cycle as an ack wins, so no request is lost
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      irq_state_r <= DBMC_IRQ_IDLE;
    end else begin
      case (irq_state_r)
        DBMC_IRQ_IDLE: begin
          if (wr_irq && i_wdata[`DBMC_BIT_SOFT_IRQ]) begin
            irq_state_r <= DBMC_IRQ_PEND;
          end
        end
        DBMC_IRQ_PEND: begin
          if (wr_irq && i_wdata[`DBMC_BIT_SOFT_IRQ]) begin
            irq_state_r <= DBMC_IRQ_PEND;
          end else if (i_proc_irq_ack) begin
            irq_state_r <= DBMC_IRQ_IDLE;
          end
        end
        default: irq_state_r <= DBMC_IRQ_IDLE;
      endcase
    end
  end

  dbmc_seed_rom u_seed (
    .i_sel  (mem_sec_r[1:0]),
    .o_seed (seed_w)
  );

  // Registered control outputs toward the processor
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_proc_gp0          <= 1'b0;
      o_proc_gp2          <= 1'b0;
      o_boot_from_ram     <= 1'b0;
      o_use_default_coefs <= 1'b0;
      o_proc_soft_irq     <= 1'b0;
      o_decrypt_enable    <= 1'b0;
      o_crc_seed          <= `DBMC_SEED_0;
    end else begin
      o_proc_gp2          <= i_gp_pin_2 & pin_fwd_r[`DBMC_BIT_FWD_PIN2];
      o_proc_gp0          <= i_gp_pin_0 & pin_fwd_r[`DBMC_BIT_FWD_PIN0];
      o_boot_from_ram     <= boot_src_r[`DBMC_BIT_BOOT_RAM];
      o_use_default_coefs <= boot_src_r[`DBMC_BIT_DEF_COEF];
      o_proc_soft_irq     <= (irq_state_r == DBMC_IRQ_PEND);
      o_decrypt_enable    <= ~mem_sec_r[`DBMC_BIT_DEC_DIS];
      o_crc_seed          <= seed_w;
    end
  end

  // Decrypt reset is write-only; nothing stored, so it clears itself after one cycle
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_decrypt_block_reset <= 1'b0;
    end else begin
      o_decrypt_block_reset <= wr_drst & i_wdata[`DBMC_BIT_DEC_RST];
    end
  end

  // Memory read gate: data is forced to zero while reads are disallowed
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_mem_rdata <= 8'h00;
    end else if (i_mem_rd && mem_sec_r[`DBMC_BIT_RD_EN]) begin
      o_mem_rdata <= i_mem_rdata;
    end else begin
      o_mem_rdata <= 8'h00;
    end
  end

  // Register readback; write-only and unmapped offsets read zero
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else if (i_addr == `DBMC_OFS_PIN_FWD) begin
      o_rdata <= pin_fwd_r;
    end else if (i_addr == `DBMC_OFS_BOOT_SRC) begin
      o_rdata <= boot_src_r;
    end else if (i_addr == `DBMC_OFS_SOFT_IRQ) begin
      o_rdata <= {7'h00, irq_state_r == DBMC_IRQ_PEND};
    end else if (i_addr == `DBMC_OFS_MEM_SEC) begin
      o_rdata <= mem_sec_r;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // Checks
  sequence s_irq_set;
    wr_irq && i_wdata[0];
  endsequence

  property p_gp2;
    @(posedge i_mclk) disable iff (!i_rst_n)
      1'b1 |=> o_proc_gp2 == ($past(i_gp_pin_2) & $past(pin_fwd_r[6]));
  endproperty
  a_gp2: assert property (p_gp2) else $error("pin 2 forward wrong");

  property p_gp0;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !pin_fwd_r[4] |=> !o_proc_gp0;
  endproperty
  a_gp0: assert property (p_gp0) else $error("pin 0 not blocked");

  property p_boot;
    @(posedge i_mclk) disable iff (!i_rst_n)
      wr_boot ##1 !wr_boot |=> o_boot_from_ram == $past(boot_src_r[1], 1);
  endproperty
  a_boot: assert property (p_boot) else $error("boot source wrong");

  property p_coef;
    @(posedge i_mclk) disable iff (!i_rst_n)
      wr_boot |=> ##1 o_use_default_coefs == $past(i_wdata[0], 2);
  endproperty
  a_coef: assert property (p_coef) else $error("coef source wrong");

  property p_irq;
    @(posedge i_mclk) disable iff (!i_rst_n)
      s_irq_set |=> ##1 o_proc_soft_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("soft irq not raised");

  property p_irq_clr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (irq_state_r == DBMC_IRQ_PEND && i_proc_irq_ack && !wr_irq) |=> ##1 !o_proc_soft_irq;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("soft irq not cleared");

  property p_rdgate;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !mem_sec_r[3] |=> o_mem_rdata == 8'h00;
  endproperty
  a_rdgate: assert property (p_rdgate) else $error("gated read not zero");

  property p_dec;
    @(posedge i_mclk) disable iff (!i_rst_n)
      1'b1 |=> o_decrypt_enable != $past(mem_sec_r[2]);
  endproperty
  a_dec: assert property (p_dec) else $error("decrypt enable wrong");

  property p_seed;
    @(posedge i_mclk) disable iff (!i_rst_n)
      mem_sec_r[1:0] == 2'h2 |=> o_crc_seed == 8'h94;
  endproperty
  a_seed: assert property (p_seed) else $error("seed wrong");

  property p_drst;
    @(posedge i_mclk) disable iff (!i_rst_n)
      wr_drst && i_wdata[0] ##1 !(wr_drst && i_wdata[0]) |=> !o_decrypt_block_reset;
  endproperty
  a_drst: assert property (p_drst) else $error("decrypt reset not self clearing");

endmodule

// File: dbmc_proc_model.sv
// Processor side: answers the soft interrupt after a chosen number of cycles
module dbmc_proc_model (
  input  wire logic       i_mclk,    // Control clock
  input  wire logic       i_irq,     // Interrupt from control block
  input  wire logic [3:0] i_ack_dly, // Cycles to wait before acking
  output logic            o_ack      // One-cycle acknowledge
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_r;
  logic       done_r;
  // One ack per request; done flag stops a second ack while the level drains
  always_ff @(posedge i_mclk) begin
    if (!i_irq) begin
      o_ack  <= 1'b0;
      wait_r <= 4'h0;
      done_r <= 1'b0;
    end else if (!done_r && wait_r == i_ack_dly) begin
      o_ack  <= 1'b1;
      done_r <= 1'b1;
    end else begin
      o_ack <= 1'b0;
      if (!done_r) begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

// File: dsp_boot_memory_control_tb.sv
module dsp_boot_memory_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dbmc_pkg::*;
  logic       mclk, rst_n, wr, rd, gp0, gp2, pgp0, pgp2, boot, coef, irq, ack, mem_rd, dec_en, dec_rst;
  logic [7:0] addr;
  logic [3:0] ack_dly;
  dbmc_byte_t wdata, rdata, mem_in, mem_out, seed;
  int         err_total, comparisons, cyc, n;
  dbmc_byte_t seeds [4] = '{8'ha5, 8'hb6, 8'h94, 8'he2};

  dbmc_ctrl i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .i_gp_pin_0(gp0), .i_gp_pin_2(gp2), .o_proc_gp0(pgp0), .o_proc_gp2(pgp2),
    .o_boot_from_ram(boot), .o_use_default_coefs(coef), .o_proc_soft_irq(irq), .i_proc_irq_ack(ack),
    .i_mem_rd(mem_rd), .i_mem_rdata(mem_in), .o_mem_rdata(mem_out), .o_decrypt_enable(dec_en),
    .o_crc_seed(seed), .o_decrypt_block_reset(dec_rst));
  dbmc_proc_model i_proc (.i_mclk(mclk), .i_irq(irq), .i_ack_dly(ack_dly), .o_ack(ack));

  // Free-running 25 MHz clock
  always #20 mclk = ~mclk;

  task automatic chk8(input dbmc_byte_t got, input dbmc_byte_t exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // Every task starts and ends just after a rising edge
  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // Strobe drops for a full cycle so back-to-back calls never retoggle it in one step
  task automatic wr_reg(input logic [7:0] a, input dbmc_byte_t d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  task automatic rd_reg(input logic [7:0] a, input dbmc_byte_t exp);
    addr = a;
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    chk8(rdata, exp);
    step(1);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the fewer than two hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end

  initial begin
    {mclk, rst_n, wr, rd, addr, wdata, ack_dly, err_total, comparisons, cyc} = '0;
    {gp0, gp2, mem_rd} = 3'b111;
    mem_in = 8'h5a;
    repeat (8) @(posedge mclk);
    #1 rst_n = 1'b1;
    step(1);
    rd_reg(8'h31, 8'h00);
    rd_reg(8'h32, 8'h00);
    rd_reg(8'h34, 8'h00);
    chk1(pgp0, 1'b0);
    chk1(pgp2, 1'b0);
    chk8(mem_out, 8'h00);
    chk8(seed, 8'ha5);
    chk1(dec_en, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h31, {1'b0, i[1], 1'b0, i[0], 4'h0});
      chk1(pgp2, i[1]);
      chk1(pgp0, i[0]);
      {gp0, gp2} = 2'b00;
      step(1);
      chk1(pgp2 | pgp0, 1'b0);
      {gp0, gp2} = 2'b11;
      step(1);
    end
    wr_reg(8'h31, 8'hff);
    rd_reg(8'h31, 8'hff);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h32, 8'(i));
      chk1(boot, i[1]);
      chk1(coef, i[0]);
      rd_reg(8'h32, 8'(i));
    end
    $display("test pins boot done");
    for (int i = 0; i < 16; i++) begin
      wr_reg(8'h34, 8'(i));
      chk8(seed, seeds[i % 4]);
      chk1(dec_en, !i[2]);
      chk8(mem_out, i[3] ? 8'h5a : 8'h00);
    end
    // Reads enabled now: data must follow the memory, and drop when no read is valid
    mem_in = 8'hc3;
    step(1);
    chk8(mem_out, 8'hc3);
    mem_rd = 1'b0;
    step(1);
    chk8(mem_out, 8'h00);
    mem_rd = 1'b1;
    $display("test security done");
    for (int i = 0; i < 2; i++) begin
      ack_dly = i ? 4'h8 : 4'h0;
      wr_reg(8'h33, 8'h01);
      chk1(irq, 1'b1);
      if (i) rd_reg(8'h33, 8'h01);
      n = 0;
      while (irq === 1'b1 && n < 20) begin
        step(1);
        n++;
      end
      chk1(irq, 1'b0);
      rd_reg(8'h33, 8'h00);
    end
    // Set on the ack edge wins; the model acks once per level, so only reset drops it
    ack_dly = 4'h0;
    wr_reg(8'h33, 8'h01);
    step(1);
    wr_reg(8'h33, 8'h01);
    step(3);
    chk1(irq, 1'b1);
    // Mid-run reset returns registers and outputs to their reset values
    rst_n = 1'b0;
    step(2);
    chk1(irq, 1'b0);
    rst_n = 1'b1;
    step(1);
    rd_reg(8'h31, 8'h00);
    rd_reg(8'h34, 8'h00);
    rd_reg(8'h33, 8'h00);
    chk8(seed, 8'ha5);
    chk1(dec_en, 1'b1);
    $display("test interrupt done");
    wr_reg(8'h34, 8'h02);
    for (int i = 1; i >= 0; i--) begin
      addr = 8'h35;
      wdata = 8'(i);
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      chk1(dec_rst, i[0]);
      step(1);
      chk1(dec_rst, 1'b0);
    end
    rd_reg(8'h35, 8'h00);
    wr_reg(8'h36, 8'hff);
    rd_reg(8'h36, 8'h00);
    rd_reg(8'h34, 8'h02);
    $display("test decrypt reset done");
    finish_test();
  end
endmodule
